/* eal_defs.svh */
// Constants for the configuration autoloader: offsets, fields, resets, counts.
// Included by the package and the loader; definitions only.
`ifndef EAL_DEFS_SVH
`define EAL_DEFS_SVH
`define EAL_SIGNATURE       16'h5AA5
`define EAL_SIG_WORD        8'h00
`define EAL_CNT_WORD        8'h01
`define EAL_OPT_WORD        8'h02
`define EAL_LAST_WORD       8'h05
`define EAL_PHY_MODE_MSB    10
`define EAL_PHY_MODE_LSB    8
`define EAL_IRQ_KIND_BIT    5
`define EAL_IRQ_POL_BIT     4
`define EAL_IDENT_BIT       2
`define EAL_CHAR_W          8'h57
`define EAL_CHAR_B          8'h42
`define EAL_FILL_LAST       5'h17
`define EAL_FILL_HI_FIRST   5'h10
`define EAL_HI_BASE         16'h0400
`define EAL_LO_END          16'h001F
`define EAL_HI_END          16'h040F
`define EAL_BUF_BASE        16'h4000
`define EAL_BUF_END         16'h7FFF
`define EAL_CSR_LIMIT       8'h80
`define EAL_IDX_STATUS      5'h10
`define EAL_IDX_CFG         5'h11
`define EAL_IDX_ADDR_LO     5'h12
`define EAL_IDX_ADDR_HI     5'h13
`define EAL_IDX_EEP_ACC     5'h14
`define EAL_IDX_BUS_TYPE_CTRL_REG        5'h15
`define EAL_EEP_GO_BIT      31
`define EAL_PHY_MODE_RST    3'h0
`define EAL_RESP_OKAY       2'h0
`define EAL_RESP_DECERR     2'h3
`endif

/* eal_pkg.sv */
// Types shared by the configuration autoloader and its helpers.
// Assumes eal_defs.svh sits in the include path.
`include "eal_defs.svh"
package eal_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_FILL, ST_DONE} eal_state_t;
	typedef enum logic [1:0] {RG_LOAD_LO, RG_LOAD_HI, RG_BUFFER, RG_RESERVED} eal_region_t;
	typedef struct packed {
		logic       req;
		logic [7:0] addr;
	} eal_eep_req_t;
	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [15:0] data;
	} eal_sram_wr_t;
endpackage : eal_pkg

/* eal_sync2.sv */
// Two-flop synchroniser for asynchronous pins, one bit per lane.
// Assumes the pins are quasi-static or slow compared with sys_clk_i.
`timescale 1ns/1ps
module eal_sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= pin_i;
			sync_o <= meta_q;
		end
	end
endmodule : eal_sync2

/* eal_local_map.sv */
// Local memory map decoder: classifies a 16-bit local address.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/1ps
`include "eal_defs.svh"
module eal_local_map
	import eal_pkg::*;
(
	input  wire logic [15:0]          addr_i,
	output eal_pkg::eal_region_t      region_o
);
	wire in_lo  = addr_i <= `EAL_LO_END;
	wire in_hi  = (addr_i >= `EAL_HI_BASE) && (addr_i <= `EAL_HI_END);
	wire in_buf = (addr_i >= `EAL_BUF_BASE) && (addr_i <= `EAL_BUF_END);
	// Everything else is reserved, including the gaps between loaded windows
	assign region_o = in_lo ? RG_LOAD_LO : in_hi ? RG_LOAD_HI :
	                  in_buf ? RG_BUFFER : RG_RESERVED;
endmodule : eal_local_map

/* eal_loader.sv */
// Configuration autoloader: reads the serial config memory word by word after
// hardware reset, fills the loaded SRAM windows and holds the option settings.
// Assumes a word-read port on sys_clk_i and an AXI4-Lite master for the CSRs.
//
// Overview of operation
// - Host config memory access register works only after the autoload finishes.
// - Every hardware reset with a 5AA5h signature copies config into SRAM 0000h-001Fh and 0400h-040Fh.
// - Loader writes SRAM only, never the station address match registers.
// - Word 0 must equal 5AA5h, otherwise memory counts as absent.
// - Word 1 is the word count; reads never go beyond it.
// - Words 3 to 5 hold address octets, low byte first.
// - Word 2 bits 10:8 select the PHY mode.
// - Word 2 bit 5 ORs into bus-type bit 5 until host writes it.
// - Word 2 bit 4 ORs into bus-type bit 4 until host writes it.
// - Word 2 bit 2 fills bytes 1Ch-1Fh with 57h, else 42h.
// - Words 00h-0Ah hold octets duplicated in both lanes; 10h-1Ah are zero.
// - 0400h-0404h pack octet pairs; 0406h-040Dh zero; 040Eh holds 5757h.
// - Packet buffer sits at 4000h-7FFFh; other gaps are reserved.
// - CSRs decode in host offsets 0000h to 007Fh.
// - Rising hardware reset latches power-on straps, including bus type.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "eal_defs.svh"
module eal_loader
	import eal_pkg::*;
(
	input  wire logic                  sys_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  hw_reset_n_i,
	input  wire logic                  cfg_mem_select_i,
	input  wire logic                  cfg_mem_clock_i,
	output eal_pkg::eal_eep_req_t      eep_req_o,
	input  wire logic                  eep_valid_i,
	input  wire logic [15:0]           eep_data_i,
	output eal_pkg::eal_sram_wr_t      sram_wr_o,
	input  wire logic [7:0]            s_axi_awaddr_i,
	input  wire logic                  s_axi_awvalid_i,
	output logic                       s_axi_awready_o,
	input  wire logic [31:0]           s_axi_wdata_i,
	input  wire logic [3:0]            s_axi_wstrb_i,
	input  wire logic                  s_axi_wvalid_i,
	output logic                       s_axi_wready_o,
	output logic [1:0]                 s_axi_bresp_o,
	output logic                       s_axi_bvalid_o,
	input  wire logic                  s_axi_bready_i,
	input  wire logic [7:0]            s_axi_araddr_i,
	input  wire logic                  s_axi_arvalid_i,
	output logic                       s_axi_arready_o,
	output logic [31:0]                s_axi_rdata_o,
	output logic [1:0]                 s_axi_rresp_o,
	output logic                       s_axi_rvalid_o,
	input  wire logic                  s_axi_rready_i,
	output logic [2:0]                 phy_mode_o,
	output logic                       irq_kind_o,
	output logic                       irq_polarity_o,
	output logic                       ident_w_o,
	output logic [1:0]                 bus_type_o,
	output logic                       load_done_o
);
	import eal_pkg::*;

	// Pin synchronisation and hardware reset edge
	logic [2:0]   pins_s;
	logic         hwr_prev_q;
	eal_sync2 #(.W(3)) u_sync (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     ({hw_reset_n_i, cfg_mem_select_i, cfg_mem_clock_i}),
		.sync_o    (pins_s)
	);
	wire hwr_s    = pins_s[2];
	wire hwr_rise = hwr_s & ~hwr_prev_q;

	eal_state_t   state_q;
	logic [7:0]   wi_q;
	logic [7:0]   cnt_q;
	logic         sig_ok_q;
	logic         done_q;
	logic         host_op_q;
	logic         host_go_q;
	logic [7:0]   host_addr_q;
	logic [15:0]  host_data_q;
	logic [7:0]   oct_q [0:5];
	logic [2:0]   phy_mode_q;
	logic         kind_load_q;
	logic         pol_load_q;
	logic         ident_q;
	logic [1:0]   bus_type_q;
	logic [7:0]   bus_type_ctrl_reg_host_q;
	logic [4:0]   fill_q;
	eal_eep_req_t eep_q;
	eal_sram_wr_t sram_q;

	// Fill sequence: indices 0-15 cover 0000h-001Eh, 16-23 cover 0400h-040Eh
	wire [15:0] fill_addr = fill_q < `EAL_FILL_HI_FIRST ? {10'h000, fill_q, 1'b0} :
	                        `EAL_HI_BASE | {11'h000, fill_q[3:0], 1'b0};
	wire [7:0]  ident_ch  = ident_q ? `EAL_CHAR_W : `EAL_CHAR_B;
	wire [2:0]  pair_idx  = {fill_q[1:0], 1'b0};
	wire [15:0] fill_data =
		fill_q < 5'd6                  ? {oct_q[fill_q[2:0]], oct_q[fill_q[2:0]]} :
		fill_q < 5'd14                 ? 16'h0000 :
		fill_q < `EAL_FILL_HI_FIRST    ? {ident_ch, ident_ch} :
		fill_q < 5'd19                 ? {oct_q[pair_idx + 3'd1], oct_q[pair_idx]} :
		fill_q < `EAL_FILL_LAST        ? 16'h0000 :
		                                 {`EAL_CHAR_W, `EAL_CHAR_W};
	eal_region_t fill_region;
	eal_local_map u_map (
		.addr_i   (fill_addr),
		.region_o (fill_region)
	);
	// Only the two loaded windows are ever written; match registers are elsewhere
	wire fill_ok = (fill_region == RG_LOAD_LO) || (fill_region == RG_LOAD_HI);

	wire eep_take  = eep_q.req & eep_valid_i;
	wire sig_match = eep_data_i == `EAL_SIGNATURE;
	wire [7:0] wi_next = wi_q + 8'd1;
	// Stop at the stored count or after the last word that carries data
	wire more_words = (wi_next < cnt_q) && (wi_q < `EAL_LAST_WORD);

	// AXI4-Lite write side
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	wire aw_fire  = s_axi_awvalid_i & s_axi_awready_o;
	wire w_fire   = s_axi_wvalid_i & s_axi_wready_o;
	wire wr_now   = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;
	wire wr_map   = aw_addr_q < `EAL_CSR_LIMIT;
	wire [4:0] wr_idx = aw_addr_q[6:2];
	wire wr_bus_type_ctrl_reg  = wr_now & wr_map & (wr_idx == `EAL_IDX_BUS_TYPE_CTRL_REG) & (|w_strb_q);
	// Host access is refused until the autoload has finished
	wire wr_eep   = wr_now & wr_map & (wr_idx == `EAL_IDX_EEP_ACC) & w_strb_q[3] &
	                w_data_q[`EAL_EEP_GO_BIT] & done_q & ~host_go_q;

	// AXI4-Lite read side
	wire ar_fire  = s_axi_arvalid_i & s_axi_arready_o;
	wire rd_map   = s_axi_araddr_i < `EAL_CSR_LIMIT;
	wire [4:0] rd_idx = s_axi_araddr_i[6:2];
	wire [7:0] bus_type_ctrl_reg_eff = bus_type_ctrl_reg_host_q | {2'b00, kind_load_q, pol_load_q, 4'h0};
	wire [31:0] rd_mux =
		!rd_map                          ? 32'h0000_0000 :
		rd_idx == `EAL_IDX_STATUS        ? {16'h0000, cnt_q, 5'h00, host_go_q, sig_ok_q, done_q} :
		rd_idx == `EAL_IDX_CFG           ? {24'h000000, bus_type_q, ident_q, 2'b00, phy_mode_q} :
		rd_idx == `EAL_IDX_ADDR_LO       ? {oct_q[3], oct_q[2], oct_q[1], oct_q[0]} :
		rd_idx == `EAL_IDX_ADDR_HI       ? {16'h0000, oct_q[5], oct_q[4]} :
		rd_idx == `EAL_IDX_EEP_ACC       ? {host_go_q, 7'h00, host_addr_q, host_data_q} :
		rd_idx == `EAL_IDX_BUS_TYPE_CTRL_REG          ? {24'h000000, bus_type_ctrl_reg_eff} :
		                                   32'h0000_0000;

	// Loader sequence
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || !hwr_s)
		begin
			state_q     <= ST_IDLE;
			wi_q        <= `EAL_SIG_WORD;
			cnt_q       <= 8'h00;
			sig_ok_q    <= 1'b0;
			done_q      <= 1'b0;
			host_op_q   <= 1'b0;
			fill_q      <= 5'h00;
			eep_q       <= '0;
			sram_q      <= '0;
			phy_mode_q  <= `EAL_PHY_MODE_RST;
			kind_load_q <= 1'b0;
			pol_load_q  <= 1'b0;
			ident_q     <= 1'b0;
			host_data_q <= 16'h0000;
			for (int i = 0; i < 6; i++)
				oct_q[i] <= 8'h00;
		end
		else
		begin
			sram_q.we <= 1'b0;
			if (wr_bus_type_ctrl_reg)
			begin
				kind_load_q <= 1'b0;
				pol_load_q  <= 1'b0;
			end
			case (state_q)
				ST_IDLE:
					if (hwr_rise)
						state_q <= ST_ISSUE;
				ST_ISSUE:
				begin
					eep_q.req  <= 1'b1;
					eep_q.addr <= host_op_q ? host_addr_q : wi_q;
					state_q    <= ST_WAIT;
				end
				ST_WAIT:
					if (eep_take)
					begin
						eep_q.req <= 1'b0;
						if (host_op_q)
						begin
							host_data_q <= eep_data_i;
							host_op_q   <= 1'b0;
							state_q     <= ST_DONE;
						end
						else if (wi_q == `EAL_SIG_WORD)
						begin
							sig_ok_q <= sig_match;
							wi_q     <= wi_next;
							// Absent or blank memory: keep every default
							state_q  <= sig_match ? ST_ISSUE : ST_DONE;
						end
						else
						begin
							if (wi_q == `EAL_CNT_WORD)
								cnt_q <= eep_data_i[7:0];
							else if (wi_q == `EAL_OPT_WORD)
							begin
								// Undefined bits of this word are never looked at
								phy_mode_q  <= eep_data_i[`EAL_PHY_MODE_MSB:`EAL_PHY_MODE_LSB];
								kind_load_q <= eep_data_i[`EAL_IRQ_KIND_BIT];
								pol_load_q  <= eep_data_i[`EAL_IRQ_POL_BIT];
								ident_q     <= eep_data_i[`EAL_IDENT_BIT];
							end
							else
							begin
								oct_q[{wi_q[1:0] - 2'd3, 1'b0}]        <= eep_data_i[7:0];
								oct_q[{wi_q[1:0] - 2'd3, 1'b0} + 3'd1] <= eep_data_i[15:8];
							end
							wi_q <= wi_next;
							if (wi_q == `EAL_CNT_WORD ? (eep_data_i[7:0] > 8'd2) : more_words)
								state_q <= ST_ISSUE;
							else
								state_q <= ST_FILL;
						end
					end
				ST_FILL:
				begin
					sram_q.we   <= fill_ok;
					sram_q.addr <= fill_addr;
					sram_q.data <= fill_data;
					fill_q      <= fill_q + 5'd1;
					if (fill_q == `EAL_FILL_LAST)
						state_q <= ST_DONE;
				end
				ST_DONE:
				begin
					done_q <= 1'b1;
					if (host_go_q && !host_op_q && !eep_q.req)
					begin
						host_op_q <= 1'b1;
						state_q   <= ST_ISSUE;
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Straps, host bus-type byte and registered outputs
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			hwr_prev_q  <= 1'b0;
			bus_type_q  <= 2'b00;
			bus_type_ctrl_reg_host_q <= 8'h00;
			host_go_q   <= 1'b0;
			host_addr_q <= 8'h00;
		end
		else
		begin
			hwr_prev_q <= hwr_s;
			if (hwr_rise)
				bus_type_q <= pins_s[1:0];
			if (wr_bus_type_ctrl_reg && w_strb_q[0])
				bus_type_ctrl_reg_host_q <= w_data_q[7:0];
			if (wr_eep)
			begin
				host_go_q   <= 1'b1;
				host_addr_q <= w_data_q[23:16];
			end
			else if (state_q == ST_WAIT && host_op_q && eep_take)
				host_go_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			phy_mode_o     <= `EAL_PHY_MODE_RST;
			irq_kind_o     <= 1'b0;
			irq_polarity_o <= 1'b0;
			ident_w_o      <= 1'b0;
			bus_type_o     <= 2'b00;
			load_done_o    <= 1'b0;
		end
		else
		begin
			phy_mode_o     <= phy_mode_q;
			irq_kind_o     <= bus_type_ctrl_reg_eff[`EAL_IRQ_KIND_BIT];
			irq_polarity_o <= bus_type_ctrl_reg_eff[`EAL_IRQ_POL_BIT];
			ident_w_o      <= ident_q;
			bus_type_o     <= bus_type_q;
			load_done_o    <= done_q;
		end
	end
	assign eep_req_o = eep_q;
	assign sram_wr_o = sram_q;

	// AXI4-Lite handshakes: one write and one read in flight
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `EAL_RESP_OKAY;
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rresp_o   <= `EAL_RESP_OKAY;
			s_axi_rdata_o   <= 32'h0000_0000;
			aw_addr_q       <= 8'h00;
			w_data_q        <= 32'h0000_0000;
			w_strb_q        <= 4'h0;
		end
		else
		begin
			if (aw_fire)
			begin
				aw_addr_q       <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (w_fire)
			begin
				w_data_q       <= s_axi_wdata_i;
				w_strb_q       <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_now)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_map ? `EAL_RESP_OKAY : `EAL_RESP_DECERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
			if (ar_fire)
			begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_mux;
				s_axi_rresp_o   <= rd_map ? `EAL_RESP_OKAY : `EAL_RESP_DECERR;
			end
			if (s_axi_rvalid_o && s_axi_rready_i)
			begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_host_after_load: assert property ((state_q == ST_ISSUE && host_op_q) |-> done_q)
		else $error("host config read started before autoload finished");
	a_sig_fail_skip: assert property ((state_q == ST_WAIT && eep_take && !host_op_q &&
		wi_q == `EAL_SIG_WORD && !sig_match && hwr_s) |=> (state_q == ST_DONE && !sig_ok_q))
		else $error("bad signature did not end the load");
	a_sig_fail_nowr: assert property ((done_q && !sig_ok_q) |-> !sram_q.we)
		else $error("SRAM written after signature failure");
	a_read_limit: assert property ((eep_q.req && !host_op_q && eep_q.addr > `EAL_CNT_WORD)
		|-> (eep_q.addr < cnt_q && eep_q.addr <= `EAL_LAST_WORD))
		else $error("config read beyond word count");
	a_phy_capture: assert property ((state_q == ST_WAIT && eep_take && !host_op_q && hwr_s &&
		wi_q == `EAL_OPT_WORD) |=> phy_mode_q == $past(eep_data_i[10:8]))
		else $error("PHY mode not taken from option word");
	// Option capture in the same cycle as a host write wins: set beats clear
	a_bus_type_ctrl_reg_clear: assert property ((wr_bus_type_ctrl_reg && !(state_q == ST_WAIT && eep_take &&
		!host_op_q && wi_q == `EAL_OPT_WORD)) |=> (!kind_load_q && !pol_load_q))
		else $error("loaded bus-type bits survived host write");
	a_ident_fill: assert property ((sram_q.we && sram_q.addr[15:2] == 14'h0007)
		|-> sram_q.data == (ident_q ? 16'h5757 : 16'h4242))
		else $error("identification bytes wrong");
	a_zero_fill: assert property ((sram_q.we && ((sram_q.addr >= 16'h0010 &&
		sram_q.addr <= 16'h001A) || (sram_q.addr >= 16'h0406 && sram_q.addr <= 16'h040C)))
		|-> sram_q.data == 16'h0000)
		else $error("reserved loaded word not zero");
	a_fill_region: assert property (sram_q.we |-> (sram_q.addr <= `EAL_LO_END ||
		(sram_q.addr >= `EAL_HI_BASE && sram_q.addr <= `EAL_HI_END)))
		else $error("loader wrote outside the loaded windows");
	a_strap_latch: assert property (hwr_rise |=> bus_type_q == $past(pins_s[1:0]))
		else $error("bus type strap not latched on reset release");
	a_csr_decode: assert property ((wr_now && !wr_map) |=>
		(s_axi_bvalid_o && s_axi_bresp_o == `EAL_RESP_DECERR))
		else $error("write outside CSR window not refused");
endmodule : eal_loader

/* eal_cfgmem_model.sv */
// Behavioural model of the serial config memory behind the word-read port.
// Assumes one request at a time; the bench fills mem and sets the latency.
`timescale 1ns/1ps
module eal_cfgmem_model
	import eal_pkg::*;
(
	input  wire logic             sys_clk_i,
	input  wire logic             sys_rst_i,
	input  eal_pkg::eal_eep_req_t req_i,
	input  wire logic [3:0]       delay_i,
	output logic                  valid_o,
	output logic [15:0]           data_o
);
	logic [15:0] mem [0:7];
	logic [3:0]  wait_q;

	// Idle data toggles so a stale word is never mistaken for an answer
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || !req_i.req || valid_o)
		begin
			wait_q  <= 4'h0;
			valid_o <= 1'b0;
			data_o  <= sys_rst_i ? 16'h0F0F : ~data_o;
		end
		else if (wait_q >= delay_i)
		begin
			valid_o <= 1'b1;
			data_o  <= mem[req_i.addr[2:0]];
		end
		else
			wait_q <= wait_q + 4'h1;
	end
endmodule : eal_cfgmem_model

/* tb.sv */
// Self-checking bench for the configuration autoloader.
// Assumes the loader and the config memory model are compiled before it.
`timescale 1ns/1ps
`include "eal_defs.svh"
module tb;
	import eal_pkg::*;
	logic         clk = 0, rst = 1, hw_n = 0, sel = 0, sck = 0, ev;
	logic         awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic         awr, wr_rdy, bv, arr, rv, ik, ip, idw, done;
	logic [7:0]   awa = 0, ara = 0;
	logic [31:0]  wd = 0, rd;
	logic [1:0]   br, rr, bt;
	logic [2:0]   phy;
	logic [3:0]   dly = 0;
	logic [15:0]  ed, wr_a [0:31], wr_d [0:31];
	eal_eep_req_t req;
	eal_sram_wr_t wr;
	int           n_fail = 0, compares = 0, wr_cnt = 0, max_a = 0;

	always #2 clk = ~clk;

	eal_loader uut (.sys_clk_i(clk), .sys_rst_i(rst), .hw_reset_n_i(hw_n),
		.cfg_mem_select_i(sel), .cfg_mem_clock_i(sck), .eep_req_o(req), .eep_valid_i(ev),
		.eep_data_i(ed), .sram_wr_o(wr), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(br),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
		.s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .phy_mode_o(phy),
		.irq_kind_o(ik), .irq_polarity_o(ip), .ident_w_o(idw), .bus_type_o(bt),
		.load_done_o(done));

	eal_cfgmem_model mdl (.sys_clk_i(clk), .sys_rst_i(rst), .req_i(req), .delay_i(dly),
		.valid_o(ev), .data_o(ed));

	// Records every SRAM write and the highest word address requested
	always @(posedge clk)
	begin
		if (wr.we === 1'b1 && wr_cnt < 32)
		begin
			wr_a[wr_cnt] = wr.addr;
			wr_d[wr_cnt] = wr.data;
			wr_cnt++;
		end
		if (req.req === 1'b1 && int'(req.addr) > max_a)
			max_a = int'(req.addr);
	end

	task finish_test;
		begin
			$display("Counts: %0d compares, %0d n_fail", compares, n_fail);
			if (n_fail == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask : finish_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			compares++;
			if (got !== exp)
			begin
				n_fail++;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask : chk

	// One AXI4-Lite transfer; each channel released at its own handshake
	task axi(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int n;
		begin
			n = 0;
			q = 32'h0;
			@(posedge clk);
			if (w)
			begin
				awa <= a;
				wd  <= d;
				awv <= 1'b1;
				wv  <= 1'b1;
				bry <= 1'b1;
			end
			else
			begin
				ara <= a;
				arv <= 1'b1;
				rry <= 1'b1;
			end
			do
			begin
				@(posedge clk);
				n++;
				if (awv && awr)
					awv <= 1'b0;
				if (wv && wr_rdy)
					wv <= 1'b0;
				if (arv && arr)
					arv <= 1'b0;
				if (bry && bv)
				begin
					bry <= 1'b0;
					r = br;
				end
				if (rry && rv)
				begin
					rry <= 1'b0;
					r = rr;
					q = rd;
				end
			end
			while ((awv || wv || bry || arv || rry) && n < 40);
			if (n >= 40)
			begin
				n_fail++;
				finish_test;
			end
		end
	endtask : axi

	function automatic logic [31:0] exp_wr(input int i, input logic w);
		logic [7:0]  o [0:5] = '{8'h10, 8'h32, 8'h54, 8'h76, 8'h98, 8'hBA};
		logic [15:0] a;
		a = (i < 16) ? 16'(2 * i) : 16'h0400 + 16'(2 * (i - 16));
		if (i < 6)
			return {a, o[i], o[i]};
		if (i < 14)
			return {a, 16'h0};
		if (i < 16)
			return {a, w ? 16'h5757 : 16'h4242};
		if (i < 19)
			return {a, o[2 * (i - 16) + 1], o[2 * (i - 16)]};
		return (i < 23) ? {a, 16'h0} : 32'h040E_5757;
	endfunction : exp_wr

	task chk_fill(input logic w);
		begin
			chk(32'(wr_cnt), 32'd24);
			for (int i = 0; i < 24; i++)
				chk({wr_a[i], wr_d[i]}, exp_wr(i, w));
		end
	endtask : chk_fill

	// Host start while the loader is held in reset must be ignored
	task load(input logic [15:0] opt, input logic [15:0] cnt, input logic sg,
		input logic [1:0] st, input logic [3:0] d);
		int          n;
		logic [31:0] q;
		logic [1:0]  r;
		begin
			@(posedge clk);
			hw_n       <= 1'b0;
			{sel, sck} <= st;
			dly        <= d;
			mdl.mem[0] = sg ? `EAL_SIGNATURE : 16'h5AA4;
			mdl.mem[1] = cnt;
			mdl.mem[2] = opt;
			repeat (4) @(posedge clk);
			axi(1'b1, 8'h50, 32'h8003_0000, q, r);
			axi(1'b0, 8'h50, 32'h0, q, r);
			chk(32'(q[31]), 32'h0);
			wr_cnt = 0;
			max_a  = 0;
			hw_n <= 1'b1;
			n = 0;
			while (done !== 1'b1 && n < 300)
			begin
				@(posedge clk);
				n++;
			end
			if (n >= 300)
			begin
				n_fail++;
				finish_test;
			end
			chk(32'(bt), 32'(st));
		end
	endtask : load

	task t_good;
		logic [31:0] q;
		logic [1:0]  r;
		int          n;
		begin
			load(16'hFDFF, 16'h0006, 1'b1, 2'b11, 4'h0);
			chk_fill(1'b1);
			chk({29'h0, phy}, 32'h5);
			chk({29'h0, ik, ip, idw}, 32'h7);
			chk(32'(max_a), 32'd5);
			axi(1'b0, 8'h40, 32'h0, q, r);
			chk(32'(q[15:0]), 32'h0603);
			axi(1'b0, 8'h48, 32'h0, q, r);
			chk(q, 32'h7654_3210);
			chk(32'(r), 32'(`EAL_RESP_OKAY));
			axi(1'b0, 8'h54, 32'h0, q, r);
			chk(32'(q[5:4]), 32'h3);
			axi(1'b1, 8'h54, 32'h0, q, r);
			chk(32'(r), 32'(`EAL_RESP_OKAY));
			// Aliases the bus-type index above the window: must be refused
			axi(1'b1, 8'hD4, 32'h0000_0030, q, r);
			chk(32'(r), 32'(`EAL_RESP_DECERR));
			axi(1'b0, 8'h54, 32'h0, q, r);
			chk({q[5:4], ik, ip}, 32'h0);
			axi(1'b1, 8'h50, 32'h8004_0000, q, r);
			n = 0;
			do
			begin
				axi(1'b0, 8'h50, 32'h0, q, r);
				n++;
			end
			while (q[31] !== 1'b0 && n < 50);
			chk(32'(q[15:0]), 32'h7654);
			axi(1'b0, 8'h80, 32'h0, q, r);
			chk(32'(r), 32'(`EAL_RESP_DECERR));
		end
	endtask : t_good

	task t_nosig;
		logic [31:0] q;
		logic [1:0]  r;
		begin
			load(16'h0734, 16'h0006, 1'b0, 2'b01, 4'h2);
			chk(32'(wr_cnt), 32'h0);
			chk(32'(max_a), 32'h0);
			chk({27'h0, phy, ik, ip}, 32'h0);
			axi(1'b0, 8'h40, 32'h0, q, r);
			chk(32'(q[1:0]), 32'h1);
		end
	endtask : t_nosig

	// Every PHY code once, slow memory, ident bit alternating
	task t_codes;
		begin
			for (int c = 0; c < 8; c++)
			begin
				load({5'h00, 3'(c), 5'h00, c[0], 2'b00}, 16'h0006, 1'b1, 2'(c), 4'h3);
				chk({29'h0, phy}, 32'(c));
				chk_fill(c[0]);
			end
		end
	endtask : t_codes

	task t_count;
		begin
			for (int c = 2; c < 4; c++)
			begin
				load(16'h0700, 16'(c), 1'b1, 2'b00, 4'h1);
				chk(32'(max_a), 32'(c - 1));
			end
		end
	endtask : t_count

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		mdl.mem[3] = 16'h3210;
		mdl.mem[4] = 16'h7654;
		mdl.mem[5] = 16'hBA98;
		t_good;
		t_nosig;
		t_codes;
		t_count;
		finish_test;
	end
endmodule : tb
